// file: design/bomc_pkg.sv
// package: addresses, field layouts and reset values of the boot option / memory size block
package bomc_pkg;

    localparam logic [15:0] BOOT_OPTION_ADDR   = 16'h0080;
    localparam logic [15:0] MEM_SIZE_ADDR      = 16'hfff0;

    localparam int          OPT_HS_SEL_BIT     = 1;
    localparam int          OPT_LS_LOCK_BIT    = 0;
    localparam logic [7:0]  OPT_USED_MASK      = 8'h03;

    localparam logic [7:0]  MEM_SIZE_RESET     = 8'hcf;
    localparam logic [7:0]  MEM_SIZE_WR_MASK   = 8'hef;
    localparam logic [2:0]  RAM_CODE_768       = 3'h0;
    localparam logic [3:0]  ROM_CODE_8K        = 4'h2;
    localparam logic [3:0]  ROM_CODE_16K       = 4'h4;

    typedef enum logic [2:0] {
        BOMC_IDLE  = 3'b001,
        BOMC_FETCH = 3'b010,
        BOMC_RUN   = 3'b100
    } bomc_phase_type;

    typedef struct packed {
        logic        hsClockSourceSelect;
        logic        lowSpeedOscLock;
    } bomc_boot_type;

    typedef struct packed {
        logic        ramSizeOk;
        logic        romSizeOk;
        logic        romIs16k;
    } bomc_size_type;

    typedef struct packed {
        bomc_phase_type phase;
        logic           fetchReq;
        bomc_boot_type  boot;
        logic [7:0]     memSizeSwitch;
        bomc_size_type  size;
        logic [7:0]     readData;
        logic           lowSpeedOscRun;
    } bomc_state_type;

endpackage : bomc_pkg

// file: design/bomc_config.sv
// boot option byte latch and memory size switching register
`timescale 1ns/1ps

module bomc_config
    import bomc_pkg::*;
(
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    output logic             flashReadReq,
    output logic [15:0]      flashReadAddr,
    input  wire logic [7:0]  flashReadData,
    input  wire logic        flashReadValid,
    input  wire logic        cpuWrite,
    input  wire logic        cpuRead,
    input  wire logic [15:0] cpuAddr,
    input  wire logic [7:0]  cpuWriteData,
    output logic [7:0]       cpuReadData,
    input  wire logic        lowSpeedOscStopReq,
    output logic             lowSpeedOscRun,
    output logic             hsClockSourceSelect,
    output logic             configReady,
    output logic             ramSizeOk,
    output logic             romSizeOk,
    output logic             romIs16k
);

    bomc_state_type state;
    bomc_state_type next_state;

    // decoded bus strokes
    logic           memSizeWrite;
    logic           memSizeRead;
    logic           bootOptionRead;
    logic           fetchTaken;

    // address compare shared by the read and the write path
    function automatic logic addrHit(
        input logic        strobe,
        input logic [15:0] addr,
        input logic [15:0] target
    );
        addrHit = strobe && (addr == target);
    endfunction

    // size legality is needed on reset and on every write
    function automatic bomc_size_type decodeSize(
        input logic [7:0] value
    );
        decodeSize = '0;
        // one legal ram code, the rest prohibited
        if (value[7:5] == RAM_CODE_768) begin
            decodeSize.ramSizeOk = 1'b1;
        end else begin
            decodeSize.ramSizeOk = 1'b0;
        end
        // two legal rom codes, the rest prohibited
        case (value[3:0])
            ROM_CODE_8K: begin
                decodeSize.romSizeOk = 1'b1;
                decodeSize.romIs16k  = 1'b0;
            end
            ROM_CODE_16K: begin
                decodeSize.romSizeOk = 1'b1;
                decodeSize.romIs16k  = 1'b1;
            end
            default: begin
                decodeSize.romSizeOk = 1'b0;
                decodeSize.romIs16k  = 1'b0;
            end
        endcase
    endfunction

    // stored form of a size byte; bit 4 never holds a one
    function automatic logic [7:0] memSizeStored(
        input logic [7:0] value
    );
        memSizeStored    = value & MEM_SIZE_WR_MASK;
        memSizeStored[4] = 1'b0;
    endfunction

    // boot fields pulled out of the flash word; upper bits never looked at
    function automatic bomc_boot_type bootFromFlash(
        input logic [7:0] flashWord
    );
        bootFromFlash                     = '0;
        bootFromFlash.hsClockSourceSelect = flashWord[OPT_HS_SEL_BIT];
        bootFromFlash.lowSpeedOscLock     = flashWord[OPT_LS_LOCK_BIT];
    endfunction

    // software view of the boot byte; upper six bits read zero
    function automatic logic [7:0] bootReadValue(
        input bomc_boot_type boot
    );
        bootReadValue                  = 8'h00;
        bootReadValue[OPT_HS_SEL_BIT]  = boot.hsClockSourceSelect;
        bootReadValue[OPT_LS_LOCK_BIT] = boot.lowSpeedOscLock;
    endfunction

    // oscillator run level; the lock wins over any stop request
    function automatic logic oscRunLevel(
        input logic locked,
        input logic stopReq
    );
        if (locked) begin
            oscRunLevel = 1'b1;
        end else begin
            oscRunLevel = !stopReq;
        end
    endfunction

    // state loaded while reset is held
    function automatic bomc_state_type resetState();
        resetState                          = '0;
        resetState.phase                    = BOMC_IDLE;
        resetState.fetchReq                 = 1'b0;
        resetState.boot.hsClockSourceSelect = 1'b0;
        // lock on until the byte is known, so the oscillator keeps running
        resetState.boot.lowSpeedOscLock     = 1'b1;
        resetState.memSizeSwitch            = memSizeStored(MEM_SIZE_RESET);
        resetState.size                     = decodeSize(MEM_SIZE_RESET);
        resetState.readData                 = 8'h00;
        resetState.lowSpeedOscRun           = 1'b1;
    endfunction

    assign memSizeWrite   = addrHit(cpuWrite, cpuAddr, MEM_SIZE_ADDR);
    assign memSizeRead    = addrHit(cpuRead, cpuAddr, MEM_SIZE_ADDR);
    assign bootOptionRead = addrHit(cpuRead, cpuAddr, BOOT_OPTION_ADDR);
    assign fetchTaken     = state.fetchReq && flashReadValid;

    always_comb begin
        next_state          = state;
        // request drops unless a phase keeps it up
        next_state.fetchReq = 1'b0;

        // boot byte fetch sequencing
        case (state.phase)
            BOMC_IDLE: begin
                // first cycle after reset release starts the fetch
                next_state.fetchReq = 1'b1;
                next_state.phase    = BOMC_FETCH;
            end
            BOMC_FETCH: begin
                if (fetchTaken) begin
                    next_state.boot  = bootFromFlash(flashReadData);
                    next_state.phase = BOMC_RUN;
                end else begin
                    next_state.fetchReq = 1'b1;
                    next_state.phase    = BOMC_FETCH;
                end
            end
            BOMC_RUN: begin
                // applied until the next reset
                next_state.phase = BOMC_RUN;
            end
            default: begin
                next_state.phase = BOMC_IDLE;
            end
        endcase

        // whole-byte write only; no bit-set path exists
        if (memSizeWrite) begin
            next_state.memSizeSwitch = memSizeStored(cpuWriteData);
            next_state.size          = decodeSize(cpuWriteData);
        end

        // read data stands one cycle; other addresses read zero
        if (memSizeRead) begin
            next_state.readData = state.memSizeSwitch;
        end else if (bootOptionRead) begin
            next_state.readData = bootReadValue(state.boot);
        end else begin
            next_state.readData = 8'h00;
        end

        // one cycle late, traded for a flop-driven output
        next_state.lowSpeedOscRun = oscRunLevel(state.boot.lowSpeedOscLock,
                                                lowSpeedOscStopReq);

        // synchronous reset overrides everything above
        if (!rstn) begin
            next_state = resetState();
        end
    end

    always_ff @(posedge sys_clk) begin
        state <= next_state;
    end

    // flash side
    assign flashReadReq        = state.fetchReq;
    assign flashReadAddr       = BOOT_OPTION_ADDR;

    // cpu side
    assign cpuReadData         = state.readData;

    // oscillator and clock selection
    assign lowSpeedOscRun      = state.lowSpeedOscRun;
    assign hsClockSourceSelect = state.boot.hsClockSourceSelect;

    // status; one-hot run bit used as is so the flag comes from a flop
    assign configReady         = state.phase[2];
    assign ramSizeOk           = state.size.ramSizeOk;
    assign romSizeOk           = state.size.romSizeOk;
    assign romIs16k            = state.size.romIs16k;

endmodule // bomc_config

// file: tb/bomc_config_asserts.sv
// assertions bound to the boot option and memory size block
`timescale 1ns/1ps
module bomc_config_asserts import bomc_pkg::*; (
    input wire logic sys_clk, rstn, flashReadReq, flashReadValid, cpuWrite, cpuRead, configReady,
    input wire logic lowSpeedOscRun, hsClockSourceSelect, ramSizeOk, romSizeOk,
    input wire logic [15:0] flashReadAddr, cpuAddr,
    input wire logic [7:0] flashReadData, cpuWriteData, cpuReadData);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    sequence fetchTaken; flashReadReq && flashReadValid; endsequence
    AST_ADDR: assert property (flashReadReq |-> flashReadAddr == 16'h0080)
        else $error("addr");
    AST_HS: assert property (fetchTaken |=> configReady &&
        hsClockSourceSelect == $past(flashReadData[1])) else $error("hs");
    AST_LOCK: assert property (fetchTaken ##0 flashReadData[0] |=> lowSpeedOscRun[*8])
        else $error("lock");
    AST_RST: assert property ($rose(rstn) |-> !ramSizeOk && !romSizeOk)
        else $error("rst");
    AST_RAM: assert property (cpuWrite && cpuAddr == 16'hfff0 |=>
        ramSizeOk == ($past(cpuWriteData[7:5]) == 3'h0)) else $error("ram");
    AST_ROM: assert property (cpuWrite && cpuAddr == 16'hfff0 |=>
        romSizeOk == ($past(cpuWriteData[3:0]) inside {4'h2, 4'h4})) else $error("rom");
    AST_BIT4: assert property (cpuRead |=> !cpuReadData[4]) else $error("b4");
    AST_HOLD: assert property (configReady |=> $stable(hsClockSourceSelect))
        else $error("hold");
endmodule // bomc_config_asserts
bind bomc_config bomc_config_asserts chk_u (.*);

// file: tb/bomc_config_test.sv
// self-checking bench for the boot option and memory size block
`timescale 1ns/1ps
module bomc_config_test import bomc_pkg::*;;
    logic sys_clk = 0, rstn = 0, flashReadValid = 0, cpuWrite = 0, cpuRead = 0, rdLate;
    // stop held high so the run output shows the latched lock directly
    logic lowSpeedOscStopReq = 1, flashReadReq, lowSpeedOscRun, hsClockSourceSelect;
    logic configReady, ramSizeOk, romSizeOk, romIs16k;
    logic [15:0] flashReadAddr, cpuAddr = 16'h0;
    logic [7:0] flashReadData = 8'h0, cpuWriteData = 8'h0, cpuReadData, expQ[$];
    logic [7:0] wv[5] = '{8'h02, 8'h04, 8'h14, 8'hcf, 8'h0};
    int miscompares = 0, n_tests = 0, n;
    always #12.5 sys_clk = ~sys_clk;
    always @(posedge sys_clk) rdLate <= cpuRead;
    always @(negedge sys_clk) if (rdLate) chk("rd", cpuReadData, expQ.pop_front());
    bomc_config dut_u (.*);
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) miscompares++;
        if (seen !== exp) $display("unexpected %s exp %h seen %h", nm, exp, seen);
    endtask
    task automatic acc(logic w, logic [15:0] a, logic [7:0] v, logic [7:0] e);
        {cpuWrite, cpuRead, cpuAddr, cpuWriteData} <= {w, !w, a, v};
        if (!w) expQ.push_back(e);
        @(posedge sys_clk) {cpuWrite, cpuRead} <= 2'h0;
        @(posedge sys_clk);
    endtask
    task automatic boot(logic [7:0] b);
        rstn <= 1'b0;
        repeat (5) @(posedge sys_clk);
        rstn <= 1'b1;
        for (n = 0; n < 20 && flashReadReq !== 1'b1; n++) @(negedge sys_clk);
        if (n == 20) begin miscompares++; tally_and_finish; end
        @(posedge sys_clk) {flashReadValid, flashReadData} <= {1'b1, b};
        @(posedge sys_clk) {flashReadValid, flashReadData} <= {1'b0, ~b};
        repeat (2) @(negedge sys_clk);
        chk("run", lowSpeedOscRun, b[0]);
        chk("hs", hsClockSourceSelect, b[1]);
        chk("ready", configReady, 1'b1);
        chk("rstsz", {romIs16k, romSizeOk, ramSizeOk}, 8'h0);
        @(posedge sys_clk);
        acc(1'b0, 16'h0080, 8'h0, b);
        acc(1'b0, 16'hfff0, 8'h0, 8'hcf);
        $display("boot %h done", b);
    endtask
    task automatic tally_and_finish;
        $display("checks %0d bad %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    initial begin
        void'($urandom(50));
        wv[4] = 8'($urandom);
        for (int k = 0; k < 4; k++) boot(8'(k));
        foreach (wv[i]) begin
            acc(1'b1, 16'hfff0, wv[i], 8'h0);
            chk("size", {romIs16k, romSizeOk, ramSizeOk}, {5'h0, (wv[i][3:0] == 4'h4),
                (wv[i][3:0] inside {4'h2, 4'h4}), (wv[i][7:5] == 3'h0)});
            acc(1'b0, 16'hfff0, 8'h0, wv[i] & 8'hef);
        end
        acc(1'b1, 16'h0080, 8'hff, 8'h0);
        acc(1'b0, 16'h0080, 8'h0, 8'h03);
        acc(1'b0, 16'h1234, 8'h0, 8'h0);
        $display("regs done");
        tally_and_finish;
    end
endmodule // bomc_config_test
